// *** rtl/rcs_channel_status.sv ***
// Control, status and interrupt coalescing for the memory to stream channel, with an AXI4-Lite slave.
// Function
// RULE1 - Threshold write of zero is ignored
// RULE2 - Simple mode ignores threshold and delay fields
// RULE3 - Delay timeout field bits 31:24, resets zero
// RULE4 - Timer reaching timeout raises delay event
// RULE5 - Zero timeout disables delay event
// RULE6 - Status bit 0 is halted, resets one
// RULE7 - SG halt needs stop, data, descriptors idle
// RULE8 - Simple halt needs stop and data idle
// RULE9 - Halted SG pointer writes start nothing
// RULE10 - Halted simple length write starts nothing
// RULE11 - SG idle when tail reached, queue done
// RULE12 - SG tail write resumes and clears idle
// RULE13 - Simple idle once transfer done, paused
// RULE14 - Idle reads zero while halted
// RULE15 - Idle zero until first transfer
// RULE16 - Status bit 2 reserved, reads zero
// RULE17 - Status bit 3 shows SG option
// RULE18 - Threshold field bits 23:16, resets one
// RULE19 - Completion events count down from threshold
// RULE20 - Delay event gated by its enable
// RULE21 - Run sets clear halted once running
`timescale 1ns/1ps
module rcs_channel_status #(
    parameter bit scatter_gather_option = 1'b1
) (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address.
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data.
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address.
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data.
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Engine activity, from logic on this clock.
    input wire logic data_busy,
    input wire logic descriptor_busy,
    input wire logic tail_reached,
    input wire logic transfer_done,
    input wire rcs_pkg::rcs_event_type engine_events,
    // Engine commands.
    output logic start_request,
    output logic [31:0] pointer_value,
    output logic [31:0] length_value,
    output logic run_stop,
    // Interrupt request.
    output logic irq_out
);
    typedef struct packed {
        logic aw_held;
        logic [11:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        rcs_pkg::rcs_control_type ctrl;
        logic halted;
        logic idle;
        logic ever_started;
        logic [3:0] stop_lag;
        logic completion_irq;
        logic delay_irq;
        logic start_request;
        logic [31:0] pointer_value;
        logic [31:0] length_value;
        logic irq_out;
    } rcs_state_type;

    rcs_state_type state;
    rcs_state_type next_state;
    logic coalesce_fire;
    logic delay_fire;
    logic coalesce_reload;
    logic do_write;
    logic do_read;
    logic [31:0] status_word;
    logic [31:0] control_word;
    logic [31:0] wmask;
    logic [7:0] new_threshold;
    logic [7:0] new_delay;
    logic engine_stopped;

    // Simple mode forces the coalescing fields out of the interrupt path. see RULE2
    rcs_coalesce_counter coalesce (
        .aclk(aclk),
        .aresetn(aresetn),
        .threshold(scatter_gather_option ? next_state.ctrl.coalesce_threshold : rcs_pkg::threshold_min),
        .reload(coalesce_reload),
        .event_in(engine_events.completion_event),
        .fire(coalesce_fire)
    );

    rcs_delay_timer delay (
        .aclk(aclk),
        .aresetn(aresetn),
        .active(scatter_gather_option), // see RULE2
        .timeout(state.ctrl.irq_delay_timeout),
        .packet_end(engine_events.packet_end),
        .packet_start(engine_events.packet_start),
        .expired(delay_fire)
    );

    assign do_write = state.aw_held && state.w_held && !state.bvalid;
    assign do_read = s_axi_arvalid && !state.rvalid;
    assign coalesce_reload = do_write && state.aw_addr == rcs_pkg::control_offset;
    assign wmask = {{8{state.w_strb[3]}}, {8{state.w_strb[2]}}, {8{state.w_strb[1]}}, {8{state.w_strb[0]}}};
    // Halting waits for descriptor activity only when that engine exists. see RULE7 see RULE8
    assign engine_stopped = !data_busy && !(scatter_gather_option && descriptor_busy);

    always_comb begin
        control_word = '0;
        control_word[rcs_pkg::run_stop_bit] = state.ctrl.run_stop;
        control_word[rcs_pkg::completion_enable_bit] = state.ctrl.completion_enable;
        control_word[rcs_pkg::delay_event_enable_bit] = state.ctrl.delay_event_enable;
        control_word[rcs_pkg::threshold_low +: 8] = state.ctrl.coalesce_threshold; // see RULE18
        control_word[rcs_pkg::delay_low +: 8] = state.ctrl.irq_delay_timeout; // see RULE3
        status_word = '0; // Bit 2 stays zero. see RULE16
        status_word[rcs_pkg::halted_bit] = state.halted; // see RULE6
        status_word[rcs_pkg::idle_bit] = state.idle;
        status_word[rcs_pkg::sg_present_bit] = scatter_gather_option; // see RULE17
        status_word[rcs_pkg::completion_irq_bit] = state.completion_irq;
        status_word[rcs_pkg::delay_irq_bit] = state.delay_irq;
        new_threshold = (control_word[rcs_pkg::threshold_low +: 8] & ~wmask[rcs_pkg::threshold_low +: 8])
            | (state.w_data[rcs_pkg::threshold_low +: 8] & wmask[rcs_pkg::threshold_low +: 8]);
        new_delay = (control_word[rcs_pkg::delay_low +: 8] & ~wmask[rcs_pkg::delay_low +: 8])
            | (state.w_data[rcs_pkg::delay_low +: 8] & wmask[rcs_pkg::delay_low +: 8]);
    end

    always_comb begin
        next_state = state;
        next_state.start_request = 1'b0;
        if (s_axi_awvalid && !state.aw_held) begin
            next_state.aw_held = 1'b1;
            next_state.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !state.w_held) begin
            next_state.w_held = 1'b1;
            next_state.w_data = s_axi_wdata;
            next_state.w_strb = s_axi_wstrb;
        end
        if (state.bvalid && s_axi_bready) begin
            next_state.bvalid = 1'b0;
        end
        if (state.rvalid && s_axi_rready) begin
            next_state.rvalid = 1'b0;
        end

        if (state.ctrl.run_stop) begin
            next_state.stop_lag = '0;
            next_state.halted = 1'b0; // see RULE21
        end else if (engine_stopped && !state.halted) begin
            // Allow the movers a few cycles to drain before reporting halted.
            if (state.stop_lag >= rcs_pkg::stop_lag_cycles) begin
                next_state.halted = 1'b1; // see RULE7 see RULE8
            end else begin
                next_state.stop_lag = state.stop_lag + 4'h1;
            end
        end else begin
            next_state.stop_lag = '0;
        end

        if (state.halted || !state.ever_started) begin
            next_state.idle = 1'b0; // see RULE14 see RULE15
        end else if (scatter_gather_option) begin
            next_state.idle = tail_reached && !descriptor_busy && !data_busy; // see RULE11
        end else begin
            next_state.idle = transfer_done && !data_busy; // see RULE13
        end

        if (do_write) begin
            next_state.aw_held = 1'b0;
            next_state.w_held = 1'b0;
            next_state.bvalid = 1'b1;
            next_state.bresp = rcs_pkg::resp_okay;
            unique case (state.aw_addr)
                rcs_pkg::control_offset: begin
                    if (state.w_strb[0]) begin
                        next_state.ctrl.run_stop = state.w_data[rcs_pkg::run_stop_bit];
                    end
                    if (state.w_strb[1]) begin
                        next_state.ctrl.completion_enable = state.w_data[rcs_pkg::completion_enable_bit];
                        next_state.ctrl.delay_event_enable = state.w_data[rcs_pkg::delay_event_enable_bit];
                    end
                    if (new_threshold != 8'h00) begin
                        next_state.ctrl.coalesce_threshold = new_threshold; // see RULE1
                    end
                    next_state.ctrl.irq_delay_timeout = new_delay; // see RULE3
                end
                rcs_pkg::status_offset: begin
                    // Writing one clears an interrupt flag.
                    if (state.w_strb[1] && state.w_data[rcs_pkg::completion_irq_bit]) begin
                        next_state.completion_irq = 1'b0;
                    end
                    if (state.w_strb[1] && state.w_data[rcs_pkg::delay_irq_bit]) begin
                        next_state.delay_irq = 1'b0;
                    end
                end
                rcs_pkg::pointer_offset: begin
                    next_state.pointer_value = state.w_data;
                    if (scatter_gather_option && !state.halted) begin
                        // A tail write resumes processing and drops idle. see RULE9 see RULE12
                        next_state.start_request = 1'b1;
                        next_state.idle = 1'b0;
                        next_state.ever_started = 1'b1;
                    end
                end
                rcs_pkg::length_offset: begin
                    next_state.length_value = state.w_data;
                    if (!scatter_gather_option && !state.halted) begin
                        next_state.start_request = 1'b1; // see RULE10
                        next_state.idle = 1'b0;
                        next_state.ever_started = 1'b1;
                    end
                end
                default: begin
                    next_state.bresp = rcs_pkg::resp_slverr;
                end
            endcase
        end

        // Flags set after the clear so a new event is never lost.
        if (coalesce_fire) begin
            next_state.completion_irq = 1'b1;
        end
        if (delay_fire) begin
            next_state.delay_irq = 1'b1; // see RULE4
        end

        if (do_read) begin
            next_state.rvalid = 1'b1;
            next_state.rresp = rcs_pkg::resp_okay;
            unique case (s_axi_araddr)
                rcs_pkg::control_offset: next_state.rdata = control_word;
                rcs_pkg::status_offset: next_state.rdata = status_word;
                rcs_pkg::pointer_offset: next_state.rdata = state.pointer_value;
                rcs_pkg::length_offset: next_state.rdata = state.length_value;
                default: begin
                    next_state.rdata = '0;
                    next_state.rresp = rcs_pkg::resp_slverr;
                end
            endcase
        end

        next_state.irq_out = (state.completion_irq && state.ctrl.completion_enable)
            || (scatter_gather_option && state.delay_irq && state.ctrl.delay_event_enable); // see RULE20 see RULE2
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= '0;
            state.halted <= 1'b1; // see RULE6
            state.ctrl.coalesce_threshold <= rcs_pkg::threshold_reset; // see RULE18
            state.ctrl.irq_delay_timeout <= rcs_pkg::delay_reset; // see RULE3
        end else begin
            state <= next_state;
        end
    end

    assign s_axi_awready = !state.aw_held;
    assign s_axi_wready = !state.w_held;
    assign s_axi_bvalid = state.bvalid;
    assign s_axi_bresp = state.bresp;
    assign s_axi_arready = !state.rvalid;
    assign s_axi_rvalid = state.rvalid;
    assign s_axi_rresp = state.rresp;
    assign s_axi_rdata = state.rdata;
    assign start_request = state.start_request;
    assign pointer_value = state.pointer_value;
    assign length_value = state.length_value;
    assign run_stop = state.ctrl.run_stop;
    assign irq_out = state.irq_out;
endmodule

// *** rtl/rcs_pkg.sv ***
// Package with register map, field layout and reset values of the channel status and coalescing block.
package rcs_pkg;
    localparam logic [11:0] control_offset = 12'h000;
    localparam logic [11:0] status_offset = 12'h004;
    localparam logic [11:0] event_offset = 12'h008;
    localparam logic [11:0] pointer_offset = 12'h00c;
    localparam logic [11:0] length_offset = 12'h010;
    localparam int run_stop_bit = 0;
    localparam int completion_enable_bit = 12;
    localparam int delay_event_enable_bit = 13;
    localparam int threshold_low = 16;
    localparam int delay_low = 24;
    localparam int halted_bit = 0;
    localparam int idle_bit = 1;
    localparam int sg_present_bit = 3;
    localparam int completion_irq_bit = 12;
    localparam int delay_irq_bit = 13;
    localparam logic [7:0] threshold_reset = 8'h01;
    localparam logic [7:0] threshold_min = 8'h01;
    localparam logic [7:0] delay_reset = 8'h00;
    localparam logic [1:0] resp_okay = 2'b00;
    localparam logic [1:0] resp_slverr = 2'b10;
    localparam logic [3:0] stop_lag_cycles = 4'h4;
    localparam logic [7:0] delay_tick_reset = 8'h00;

    typedef struct packed {
        logic run_stop;
        logic completion_enable;
        logic delay_event_enable;
        logic [7:0] coalesce_threshold;
        logic [7:0] irq_delay_timeout;
    } rcs_control_type;

    typedef struct packed {
        logic halted;
        logic idle;
        logic sg_engine_present;
    } rcs_status_type;

    typedef struct packed {
        logic packet_end;
        logic packet_start;
        logic completion_event;
    } rcs_event_type;
endpackage

// *** rtl/rcs_delay_timer.sv ***
// Interrupt delay timer that runs from the end of a packet to the programmed timeout.
`timescale 1ns/1ps
module rcs_delay_timer (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Control.
    input wire logic active,
    input wire logic [7:0] timeout,
    input wire logic packet_end,
    input wire logic packet_start,
    // Result.
    output logic expired
);
    typedef struct packed {
        logic running;
        logic [7:0] count;
        logic expired;
    } rcs_timer_type;

    rcs_timer_type state;
    rcs_timer_type next_state;

    always_comb begin
        next_state = state;
        next_state.expired = 1'b0;
        if (!active || timeout == 8'h00) begin
            // A zero timeout stops the timer so it can never fire. see RULE5
            next_state.running = 1'b0;
            next_state.count = 8'h00;
        end else if (packet_start) begin
            next_state.running = 1'b0; // see RULE3
            next_state.count = 8'h00;
        end else if (packet_end) begin
            next_state.running = 1'b1; // see RULE3
            next_state.count = 8'h00;
        end else if (state.running) begin
            if (state.count + 8'h01 >= timeout) begin
                next_state.expired = 1'b1; // see RULE4
                next_state.running = 1'b0; // see RULE3
                next_state.count = 8'h00;
            end else begin
                next_state.count = state.count + 8'h01;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign expired = state.expired;
endmodule

// *** rtl/rcs_coalesce_counter.sv ***
// Completion event counter that fires once per threshold events.
`timescale 1ns/1ps
module rcs_coalesce_counter (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Control.
    input wire logic [7:0] threshold,
    input wire logic reload,
    input wire logic event_in,
    // Result.
    output logic fire
);
    typedef struct packed {
        logic [7:0] count;
        logic fire;
    } rcs_count_type;

    rcs_count_type state;
    rcs_count_type next_state;

    always_comb begin
        next_state = state;
        next_state.fire = 1'b0;
        if (reload) begin
            next_state.count = threshold;
        end else if (event_in) begin
            if (state.count <= 8'h01) begin
                // Count reached zero: fire and reload. see RULE19
                next_state.fire = 1'b1;
                next_state.count = threshold;
            end else begin
                next_state.count = state.count - 8'h01; // see RULE19
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state.count <= rcs_pkg::threshold_reset;
            state.fire <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    assign fire = state.fire;
endmodule

// *** testbench/rcs_channel_status_checker.sv ***
// Concurrent checks on the ports of the channel status block.
`timescale 1ns/1ps
module rcs_channel_status_checker #(
    parameter bit scatter_gather_option = 1'b1
) (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus.
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Engine side.
    input wire logic start_request,
    input wire logic run_stop
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence write_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence read_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    aw_hold_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("write address taken twice");
    write_answer_a: assert property (write_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write response missing");
    b_stable_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    r_answer_a: assert property (read_taken |=> s_axi_rvalid)
        else $error("read data missing");
    r_stable_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while answer pending");
    status_bits_a: assert property (read_taken ##0 s_axi_araddr == rcs_pkg::status_offset |=>
        s_axi_rdata[2] == 1'b0 && s_axi_rdata[3] == scatter_gather_option) else $error("status low bits wrong");
    unmapped_a: assert property (read_taken ##0 s_axi_araddr == 12'h008 |=>
        s_axi_rresp == rcs_pkg::resp_slverr && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
    start_gate_a: assert property (start_request |-> $past(run_stop))
        else $error("start issued while stopped");
    start_pulse_a: assert property (start_request |=> !start_request)
        else $error("start longer than one cycle");
endmodule
bind rcs_channel_status rcs_channel_status_checker #(.scatter_gather_option(scatter_gather_option)) u_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .start_request(start_request), .run_stop(run_stop));

// *** testbench/testbench.sv ***
// Self-checking bench for the channel status and coalescing block in both modes.
`timescale 1ns/1ps
module testbench;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, resp_seen;
    logic [31:0] rdata, rdata_s, rd, rd_s;
    logic data_busy = 1'b0, descriptor_busy = 1'b0, tail_reached = 1'b0, transfer_done = 1'b0;
    rcs_pkg::rcs_event_type ev = 3'b000;
    logic start_request, start_s, run_stop, irq_out, irq_s;
    int error_cnt = 0, tests_run = 0, starts = 0, starts_s = 0;

    always #50 aclk = ~aclk;
    always @(negedge aclk) begin
        if (start_request === 1'b1) starts++;
        if (start_s === 1'b1) starts_s++;
    end

    // Both modes see the same bus traffic; only the scatter-gather copy answers the handshakes.
    rcs_channel_status #(.scatter_gather_option(1'b1)) dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .data_busy(data_busy), .descriptor_busy(descriptor_busy),
        .tail_reached(tail_reached), .transfer_done(transfer_done), .engine_events(ev),
        .start_request(start_request), .pointer_value(), .length_value(), .run_stop(run_stop), .irq_out(irq_out));
    rcs_channel_status #(.scatter_gather_option(1'b0)) dut_simple (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(), .s_axi_bresp(),
        .s_axi_bvalid(), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(), .s_axi_rdata(rdata_s), .s_axi_rresp(), .s_axi_rvalid(),
        .s_axi_rready(rready), .data_busy(data_busy), .descriptor_busy(descriptor_busy),
        .tail_reached(tail_reached), .transfer_done(transfer_done), .engine_events(ev),
        .start_request(start_s), .pointer_value(), .length_value(), .run_stop(), .irq_out(irq_s));

    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic logic pick(input int k);
        case (k)
            0: return bvalid;
            1: return arready;
            default: return rvalid;
        endcase
    endfunction

    // Every wait is bounded so a stuck handshake ends the run instead of hanging it.
    task automatic wait_hi(input int k);
        for (int n = 0; n < 200; n++) begin
            @(posedge aclk);
            if (pick(k) === 1'b1) return;
        end
        error_cnt++;
        stop_test();
    endtask

    task automatic axi_write(input logic [11:0] a, input logic [31:0] d);
        bit aw;
        bit w;
        int n;
        aw = 1'b1;
        w = 1'b1;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while ((aw || w) && n < 200) begin
            @(posedge aclk);
            n++;
            if (aw && awready === 1'b1) begin
                aw = 1'b0;
                awvalid <= 1'b0;
            end
            if (w && wready === 1'b1) begin
                w = 1'b0;
                wvalid <= 1'b0;
            end
        end
        if (aw || w) begin
            error_cnt++;
            stop_test();
        end
        bready <= 1'b1;
        wait_hi(0);
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [11:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        wait_hi(1);
        arvalid <= 1'b0;
        rready <= 1'b1;
        wait_hi(2);
        rd = rdata;
        rd_s = rdata_s;
        resp_seen = rresp;
        rready <= 1'b0;
    endtask

    task automatic pulse(input rcs_pkg::rcs_event_type e);
        ev <= e;
        @(posedge aclk);
        ev <= 3'b000;
        repeat (6) @(posedge aclk);
    endtask

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_read(rcs_pkg::control_offset);
        check("control reset", rd & 32'hffff0000, 32'h00010000);
        axi_read(rcs_pkg::status_offset);
        check("status reset", rd & 32'hf, 32'h9);
        check("simple status reset", rd_s & 32'hf, 32'h1);
        $display("Test reset values done");
        axi_write(rcs_pkg::control_offset, 32'h05000000);
        axi_read(rcs_pkg::control_offset);
        check("zero threshold", rd & 32'hffff0000, 32'h05010000);
        axi_write(rcs_pkg::status_offset, 32'h4);
        axi_read(rcs_pkg::status_offset);
        check("reserved bit", rd & 32'hf, 32'h9);
        axi_read(12'h008);
        check("unmapped resp", resp_seen, rcs_pkg::resp_slverr);
        check("unmapped data", rd, 32'h0);
        $display("Test register fields done");
        axi_write(rcs_pkg::pointer_offset, 32'h100);
        axi_write(rcs_pkg::length_offset, 32'h40);
        check("halted starts", starts + starts_s, 0);
        tail_reached <= 1'b1;
        transfer_done <= 1'b1;
        axi_write(rcs_pkg::control_offset, 32'h00033001);
        check("run_stop", run_stop, 1'b1);
        axi_read(rcs_pkg::status_offset);
        check("running status", rd & 32'hf, 32'h8);
        check("simple running status", rd_s & 32'hf, 32'h0);
        axi_write(rcs_pkg::pointer_offset, 32'h200);
        check("pointer start", starts, 1);
        axi_write(rcs_pkg::length_offset, 32'h80);
        check("length start", starts_s != 0, 1'b1);
        axi_read(rcs_pkg::status_offset);
        check("idle", rd & 32'hf, 32'ha);
        check("simple idle", rd_s & 32'hf, 32'h2);
        $display("Test run and idle done");
        pulse(3'b001);
        check("simple irq", irq_s, 1'b1);
        pulse(3'b001);
        check("irq early", irq_out, 1'b0);
        pulse(3'b001);
        check("irq at threshold", irq_out, 1'b1);
        axi_write(rcs_pkg::status_offset, 32'h3000);
        @(posedge aclk);
        check("irq cleared", irq_out, 1'b0);
        $display("Test coalescing done");
        axi_write(rcs_pkg::control_offset, 32'h04033001);
        pulse(3'b100);
        repeat (20) @(posedge aclk);
        check("delay irq", irq_out, 1'b1);
        check("simple delay irq", irq_s, 1'b0);
        axi_write(rcs_pkg::status_offset, 32'h3000);
        axi_write(rcs_pkg::control_offset, 32'h04031001);
        pulse(3'b100);
        repeat (20) @(posedge aclk);
        axi_read(rcs_pkg::status_offset);
        check("delay flag", rd & 32'h2000, 32'h2000);
        check("delay gated", irq_out, 1'b0);
        axi_write(rcs_pkg::status_offset, 32'h3000);
        axi_write(rcs_pkg::control_offset, 32'h00033001);
        pulse(3'b100);
        repeat (20) @(posedge aclk);
        axi_read(rcs_pkg::status_offset);
        check("zero delay", rd & 32'h2000, 32'h0);
        $display("Test delay timer done");
        data_busy <= 1'b1;
        axi_write(rcs_pkg::control_offset, 32'h00033000);
        repeat (10) @(posedge aclk);
        axi_read(rcs_pkg::status_offset);
        check("busy halt", (rd & 32'h1) | (rd_s & 32'h1), 32'h0);
        data_busy <= 1'b0;
        descriptor_busy <= 1'b1;
        repeat (10) @(posedge aclk);
        axi_read(rcs_pkg::status_offset);
        check("descriptor halt", rd & 32'h1, 32'h0);
        check("simple halt", rd_s & 32'h3, 32'h1);
        descriptor_busy <= 1'b0;
        repeat (10) @(posedge aclk);
        axi_read(rcs_pkg::status_offset);
        check("halted", rd & 32'h3, 32'h1);
        $display("Test halt done");
        stop_test();
    end
endmodule
